// ==== src/cvr_pkg.sv ====
// Constants and register map of the cell voltage result bank.
package cvr_pkg;

    // ------------------------------------------------------------
    // Bank shape
    // ------------------------------------------------------------
    localparam int CELL_COUNT = 4;
    localparam int CELL_SEL_W = 2;
    localparam int CODE_W = 14;
    localparam int REG_W = 16;
    localparam int FIELD_MSB = 15;
    localparam int FIELD_LSB = 2;
    localparam int IDX_W = 10;

    // ------------------------------------------------------------
    // Conversion scaling
    // ------------------------------------------------------------
    // Full-scale code stands for a 5 V differential input
    localparam int FULL_SCALE_MV = 5000;
    localparam logic [CODE_W-1:0] CODE_FULL_SCALE = 14'h3FFF;
    localparam logic [CODE_W-1:0] CODE_RESET = 14'h0000;
    localparam logic [REG_W-1:0] RESULT_RESET = 16'h0000;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [IDX_W-1:0] FIFTH_CELL_RESULT_IDX = 10'h04B;
    localparam logic [IDX_W-1:0] SIXTH_CELL_RESULT_IDX = 10'h04C;
    localparam logic [IDX_W-1:0] SEVENTH_CELL_RESULT_IDX = 10'h04D;
    localparam logic [IDX_W-1:0] EIGHTH_CELL_RESULT_IDX = 10'h04E;
    localparam logic [IDX_W-1:0] CTRL_IDX = 10'h060;
    localparam logic [IDX_W-1:0] STAT_IDX = 10'h061;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int CTRL_ENABLE_LSB = 0;
    localparam int CTRL_FILT_BIT = 4;
    localparam logic [CELL_COUNT-1:0] CTRL_ENABLE_RESET = 4'hF;
    localparam logic CTRL_FILT_RESET = 1'b0;

    // ------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------
    localparam int STAT_SKIP_LSB = 0;
    localparam int STAT_FRESH_LSB = 4;
    localparam int STAT_BUSY_BIT = 8;
    localparam int STAT_COUNT_LSB = 16;
    localparam int SCAN_COUNT_W = 8;
    localparam logic [CELL_COUNT-1:0] SKIP_RESET = 4'h0;

    // ------------------------------------------------------------
    // AHB-Lite codes
    // ------------------------------------------------------------
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'b0;
    localparam logic [31:0] HRDATA_RESET = 32'h0000_0000;

endpackage

// ==== src/cvr_cell_slot.sv ====
// Storage of one cell's averaged and filtered conversion result.
`timescale 1ns/10ps

module cvr_cell_slot (
    // Clock, reset and freeze
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    // Result from the scan
    input wire logic load,
    input wire logic overrange,
    input wire logic [cvr_pkg::CODE_W-1:0] avg_in,
    input wire logic [cvr_pkg::CODE_W-1:0] iir_in,
    // Readback
    input wire logic filt_sel,
    output logic [cvr_pkg::REG_W-1:0] value
);
    import cvr_pkg::*;

    typedef struct packed {
        logic [CODE_W-1:0] avg;
        logic [CODE_W-1:0] iir;
    } cvr_slot_t;

    cvr_slot_t state_reg;
    cvr_slot_t state_next;
    logic [CODE_W-1:0] code;

    always_comb begin
        state_next = state_reg;
        if (load) begin
            if (overrange) begin
                // Clip to the code that stands for 5 V
                state_next.avg = CODE_FULL_SCALE; // see (R02)
                state_next.iir = CODE_FULL_SCALE; // see (R02)
            end else begin
                state_next.avg = avg_in;
                state_next.iir = iir_in;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= '{avg: CODE_RESET, iir: CODE_RESET};
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    assign code = filt_sel ? state_reg.iir : state_reg.avg; // see (R04)
    assign value = {code, {FIELD_LSB{1'b0}}}; // see (R01) see (R07)

endmodule

// ==== src/cvr_regs.sv ====
// Cell five to eight voltage result registers with their AHB-Lite slave.
`timescale 1ns/10ps

// Functional notes
// (R01) Result code of 14 bits sits in bits 15:2, MSB at bit 15.
// (R02) Full-scale code corresponds to a 5 V differential cell input.
// (R03) Disabled cell skipped in latest scan keeps its stored result data.
// (R04) Skipped cell reads averaged or filtered result per readback select.
// (R05) Result registers are read-only; host writes change nothing.
// (R06) One register per cell, cells five to eight at indices 0x4B to 0x4E.
// (R07) Bits 1:0 read zero; every result register reads zero after reset.
module cvr_regs (
    // Clock, reset and freeze
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Scan result bus
    input wire logic scan_start,
    input wire logic scan_done,
    input wire logic result_valid,
    input wire logic [cvr_pkg::CELL_SEL_W-1:0] result_cell,
    input wire logic [cvr_pkg::CODE_W-1:0] result_avg,
    input wire logic [cvr_pkg::CODE_W-1:0] result_iir,
    input wire logic result_overrange,
    // Configuration seen by the rest of the unit
    output logic [cvr_pkg::CELL_COUNT-1:0] cell_measure_enable,
    output logic filtered_readback_select
);
    import cvr_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
        logic wr_pend;
        logic [IDX_W-1:0] wr_idx;
        logic [CELL_COUNT-1:0] enable;
        logic filt_sel;
        logic scan_busy;
        logic [CELL_COUNT-1:0] seen;
        logic [CELL_COUNT-1:0] skip;
        logic [CELL_COUNT-1:0] fresh;
        logic [SCAN_COUNT_W-1:0] scan_count;
    } cvr_state_t;

    localparam cvr_state_t STATE_RESET = '{
        hrdata: HRDATA_RESET,
        hreadyout: 1'b1,
        hresp: HRESP_OKAY,
        wr_pend: 1'b0,
        wr_idx: '0,
        enable: CTRL_ENABLE_RESET,
        filt_sel: CTRL_FILT_RESET,
        scan_busy: 1'b0,
        seen: SKIP_RESET,
        skip: SKIP_RESET,
        fresh: SKIP_RESET,
        scan_count: '0
    };

    cvr_state_t state_reg;
    cvr_state_t state_next;

    // ------------------------------------------------------------
    // Address phase decode
    // ------------------------------------------------------------
    logic addr_ok;
    logic [IDX_W-1:0] addr_idx;
    logic access;
    logic rd_access;
    logic wr_access;
    logic [CELL_COUNT-1:0] cell_load;
    logic [REG_W-1:0] cell_value [CELL_COUNT];

    assign addr_idx = haddr[IDX_W+1:2];
    // Only aligned word addresses inside the first 4 KiB are mapped
    assign addr_ok = (haddr[31:IDX_W+2] == '0) && (haddr[1:0] == 2'h0);
    assign access = hsel && hready && (htrans == HTRANS_NONSEQ);
    assign rd_access = access && !hwrite;
    assign wr_access = access && hwrite && (hsize == HSIZE_WORD) && addr_ok;

    // ------------------------------------------------------------
    // Per cell result storage
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < CELL_COUNT; gi++) begin : g_cell
            // Disabled cells get no load, so their data stays put
            assign cell_load[gi] = result_valid && state_reg.enable[gi] &&
                (result_cell == CELL_SEL_W'(gi)); // see (R03)

            cvr_cell_slot u_slot (
                .hclk(hclk),
                .hresetn(hresetn),
                .clk_en(clk_en),
                .load(cell_load[gi]),
                .overrange(result_overrange),
                .avg_in(result_avg),
                .iir_in(result_iir),
                .filt_sel(state_reg.filt_sel),
                .value(cell_value[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Register views
    // ------------------------------------------------------------
    logic [31:0] ctrl_view;
    logic [31:0] stat_view;
    logic [CELL_COUNT-1:0] ctrl_enable_fwd;
    logic ctrl_filt_fwd;
    logic ctrl_wr_now;

    // Write data of a pending control write is forwarded so a read
    // right behind it sees the new value, not the stale one
    assign ctrl_wr_now = state_reg.wr_pend && (state_reg.wr_idx == CTRL_IDX);
    assign ctrl_enable_fwd = ctrl_wr_now ?
        hwdata[CTRL_ENABLE_LSB +: CELL_COUNT] : state_reg.enable;
    assign ctrl_filt_fwd = ctrl_wr_now ? hwdata[CTRL_FILT_BIT] : state_reg.filt_sel;

    always_comb begin
        ctrl_view = '0;
        ctrl_view[CTRL_ENABLE_LSB +: CELL_COUNT] = ctrl_enable_fwd;
        ctrl_view[CTRL_FILT_BIT] = ctrl_filt_fwd;
    end

    always_comb begin
        stat_view = '0;
        stat_view[STAT_SKIP_LSB +: CELL_COUNT] = state_reg.skip;
        stat_view[STAT_FRESH_LSB +: CELL_COUNT] = state_reg.fresh;
        stat_view[STAT_BUSY_BIT] = state_reg.scan_busy;
        stat_view[STAT_COUNT_LSB +: SCAN_COUNT_W] = state_reg.scan_count;
    end

    // ------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------
    logic [31:0] rd_value;
    logic [CELL_COUNT-1:0] cell_hit;

    always_comb begin
        rd_value = '0;
        cell_hit = '0;
        if (!addr_ok) begin
            // Unmapped space reads as zero with an OKAY answer
            rd_value = '0;
        end else if (addr_idx == FIFTH_CELL_RESULT_IDX) begin
            rd_value = {16'h0000, cell_value[0]}; // see (R06)
            cell_hit[0] = 1'b1;
        end else if (addr_idx == SIXTH_CELL_RESULT_IDX) begin
            rd_value = {16'h0000, cell_value[1]}; // see (R06)
            cell_hit[1] = 1'b1;
        end else if (addr_idx == SEVENTH_CELL_RESULT_IDX) begin
            rd_value = {16'h0000, cell_value[2]}; // see (R06)
            cell_hit[2] = 1'b1;
        end else if (addr_idx == EIGHTH_CELL_RESULT_IDX) begin
            rd_value = {16'h0000, cell_value[3]}; // see (R06)
            cell_hit[3] = 1'b1;
        end else if (addr_idx == CTRL_IDX) begin
            rd_value = ctrl_view;
        end else if (addr_idx == STAT_IDX) begin
            rd_value = stat_view;
        end else begin
            rd_value = '0;
        end
    end

    // ------------------------------------------------------------
    // Scan bookkeeping
    // ------------------------------------------------------------
    logic [CELL_COUNT-1:0] seen_now;
    logic [CELL_COUNT-1:0] fresh_clear;

    // A result landing together with scan_done still counts as seen
    assign seen_now = (scan_start ? '0 : state_reg.seen) | cell_load;
    assign fresh_clear = rd_access ? cell_hit : '0;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;

        // Zero wait states, response always OKAY
        state_next.hreadyout = 1'b1;
        state_next.hresp = HRESP_OKAY;

        // Read data is taken in the address phase and shown next cycle
        if (rd_access) begin
            state_next.hrdata = rd_value;
        end

        // Write data phase: only the control register takes data;
        // result and status words silently keep their content
        if (state_reg.wr_pend) begin
            if (state_reg.wr_idx == CTRL_IDX) begin
                state_next.enable = hwdata[CTRL_ENABLE_LSB +: CELL_COUNT];
                state_next.filt_sel = hwdata[CTRL_FILT_BIT];
            end
        end

        // Capture a new write address phase
        if (access) begin
            state_next.wr_pend = wr_access;
            state_next.wr_idx = addr_idx;
        end else if (hready) begin
            state_next.wr_pend = 1'b0;
        end

        // Scan tracking
        if (scan_start) begin
            state_next.scan_busy = 1'b1;
        end
        if (scan_start || state_reg.scan_busy) begin
            state_next.seen = seen_now;
        end
        if (scan_done && (state_reg.scan_busy || scan_start)) begin
            // Cells with no result in this scan were skipped
            state_next.skip = ~seen_now; // see (R03) see (R04)
            state_next.scan_busy = 1'b0;
            state_next.scan_count = state_reg.scan_count + SCAN_COUNT_W'(1);
        end

        // Fresh flag: a new load wins over a clearing read
        state_next.fresh = (state_reg.fresh & ~fresh_clear) | cell_load;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= STATE_RESET; // see (R07)
        end else if (clk_en) begin
            state_reg <= state_next; // see (R05)
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign hrdata = state_reg.hrdata;
    assign hreadyout = state_reg.hreadyout;
    assign hresp = state_reg.hresp;
    assign cell_measure_enable = state_reg.enable;
    assign filtered_readback_select = state_reg.filt_sel;

endmodule

// ==== testbench/cvr_regs_chk.sv ====
// Concurrent checks on the ports of the cell voltage result bank.
`timescale 1ns/10ps
module cvr_regs_chk (
    // Clock, reset and freeze
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Configuration
    input wire logic [cvr_pkg::CELL_COUNT-1:0] cell_measure_enable,
    input wire logic filtered_readback_select
);
    import cvr_pkg::*;
    // ------------------------------------------------------------
    // Data phase tracking
    // ------------------------------------------------------------
    logic ap;
    logic lo;
    logic is_cell;
    logic is_ctrl;
    logic [3:0] ph;
    assign ap = hsel && hready && htrans == HTRANS_NONSEQ && clk_en && hsize == HSIZE_WORD;
    assign lo = haddr[31:12] == 20'h00000 && haddr[1:0] == 2'h0;
    assign is_cell = lo && haddr[11:2] >= FIFTH_CELL_RESULT_IDX && haddr[11:2] <= EIGHTH_CELL_RESULT_IDX;
    assign is_ctrl = lo && haddr[11:2] == CTRL_IDX;
    // Bits: control write, unmapped read, cell read, control read
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph <= 4'h0;
        end else if (clk_en) begin
            ph <= {ap && hwrite && is_ctrl,
                   ap && !hwrite && !is_cell && !is_ctrl && !(lo && haddr[11:2] == STAT_IDX),
                   ap && !hwrite && is_cell, ap && !hwrite && is_ctrl};
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_zero_wait: assert property (ap |=> hreadyout)
        else $error("wait state inserted");
    a_resp_okay: assert property (hresp == HRESP_OKAY)
        else $error("error response");
    a_unused_bits: assert property (ph[1] |-> hrdata[31:16] == 16'h0000 && hrdata[1:0] == 2'h0)
        else $error("unused result bits not zero");
    a_unmapped_zero: assert property (ph[2] |-> hrdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_ctrl_readback: assert property (ph[0] |-> hrdata[4:0] ==
        {filtered_readback_select, cell_measure_enable}) else $error("control readback");
    a_rdata_holds: assert property ($changed(hrdata) |-> $past(ap && !hwrite))
        else $error("read data moved without a read");
    a_enable_by_write: assert property ($changed(cell_measure_enable) |-> $past(ph[3]))
        else $error("enable moved without a write");
    a_select_by_write: assert property ($changed(filtered_readback_select) |-> $past(ph[3]))
        else $error("select moved without a write");
endmodule

bind cvr_regs cvr_regs_chk chk_u (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hready, .hrdata, .hreadyout, .hresp, .cell_measure_enable, .filtered_readback_select);

// ==== testbench/testbench.sv ====
// Self-checking bench for the cell voltage result bank.
`timescale 1ns/10ps
module testbench;
    import cvr_pkg::*;
    logic hclk = 1'b0;
    logic hresetn, clk_en, hsel, hwrite, hready, hreadyout, hresp, sel_q;
    logic scan_start, scan_done, result_valid, result_overrange, filtered_readback_select;
    logic [31:0] haddr, hwdata, hrdata, junk;
    logic [1:0] htrans, result_cell;
    logic [2:0] hsize;
    logic [13:0] result_avg, result_iir;
    logic [3:0] cell_measure_enable;
    logic [13:0] avg_e [4];
    logic [13:0] iir_e [4];
    int error_cnt = 0;
    int checks = 0;
    always #4 hclk = ~hclk;
    assign hready = hreadyout;
    cvr_regs dut_u (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hrdata, .hreadyout, .hresp, .scan_start, .scan_done, .result_valid,
        .result_cell, .result_avg, .result_iir, .result_overrange, .cell_measure_enable,
        .filtered_readback_select);
    // ------------------------------------------------------------
    // Bus and scan tasks
    // ------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Bounded so a stuck slave cannot hang the run
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            error_cnt++;
            report_and_stop();
        end
    endtask
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        wait_rdy();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
    endtask
    task automatic rd_chk(input string nm, input logic [31:0] a, input logic [31:0] e);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0000_0000, q);
        chk(nm, q, e);
    endtask
    task automatic set_ctrl(input logic [3:0] en, input logic s);
        xfer(1'b1, 32'(CTRL_IDX) << 2, {27'h0000000, s, en}, junk);
        sel_q = s;
    endtask
    function automatic logic [31:0] cell_exp(int i);
        return {16'h0000, sel_q ? iir_e[i] : avg_e[i], 2'h0};
    endfunction
    function automatic logic [31:0] cell_addr(int i);
        return 32'(FIFTH_CELL_RESULT_IDX + 10'(i)) << 2;
    endfunction
    task automatic scan(input logic [3:0] en, input logic [13:0] base, input int ovr);
        logic [13:0] v;
        scan_start <= 1'b1;
        @(posedge hclk);
        scan_start <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            v = base + 14'(i * 'h111);
            result_valid <= 1'b1;
            result_cell <= 2'(i);
            result_avg <= v;
            result_iir <= ~v;
            result_overrange <= (i == ovr);
            if (en[i]) begin
                avg_e[i] = (i == ovr) ? CODE_FULL_SCALE : v;
                iir_e[i] = (i == ovr) ? CODE_FULL_SCALE : ~v;
            end
            @(posedge hclk);
        end
        result_valid <= 1'b0;
        scan_done <= 1'b1;
        @(posedge hclk);
        scan_done <= 1'b0;
    endtask
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        {hresetn, hsel, hwrite, scan_start, scan_done, result_valid, result_overrange} = 7'h00;
        {haddr, hwdata, htrans, result_cell, result_avg, result_iir} = 96'h0;
        clk_en = 1'b1;
        hsize = HSIZE_WORD;
        sel_q = CTRL_FILT_RESET;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 4; i++) rd_chk("reset value", cell_addr(i), 32'h0);
        rd_chk("control reset", 32'(CTRL_IDX) << 2, {27'h0, CTRL_FILT_RESET, CTRL_ENABLE_RESET});
        rd_chk("unmapped", 32'h0000_0140, 32'h0);
        $display("test reset done");
        scan(4'hF, 14'h3FFF, 3);
        for (int i = 0; i < 4; i++) rd_chk("averaged", cell_addr(i), cell_exp(i));
        set_ctrl(4'hF, 1'b1);
        for (int i = 0; i < 4; i++) rd_chk("filtered", cell_addr(i), cell_exp(i));
        $display("test placement done");
        for (int i = 0; i < 4; i++) xfer(1'b1, cell_addr(i), 32'hFFFF_FFFF, junk);
        for (int i = 0; i < 4; i++) rd_chk("after write", cell_addr(i), cell_exp(i));
        $display("test read only done");
        set_ctrl(4'hE, 1'b1);
        // Control outputs move on the data phase edge, so look one edge later
        @(posedge hclk);
        chk("enable output", 32'(cell_measure_enable), 32'h0000_000E);
        chk("select output", 32'(filtered_readback_select), 32'h0000_0001);
        scan(4'hE, 14'h0A5A, 4);
        rd_chk("status", 32'(STAT_IDX) << 2, 32'h0002_00E1);
        for (int i = 0; i < 4; i++) rd_chk("skip filt", cell_addr(i), cell_exp(i));
        set_ctrl(4'hE, 1'b0);
        for (int i = 0; i < 4; i++) rd_chk("skip avg", cell_addr(i), cell_exp(i));
        $display("test skipped cell done");
        // Frozen clock enable: a whole scan must leave every result alone
        clk_en <= 1'b0;
        scan(4'h0, 14'h1234, 4);
        clk_en <= 1'b1;
        for (int i = 0; i < 4; i++) rd_chk("frozen", cell_addr(i), cell_exp(i));
        $display("test freeze done");
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 4; i++) rd_chk("second reset", cell_addr(i), 32'h0);
        $display("test second reset done");
        report_and_stop();
    end
endmodule
